/* File: inc/ntbt_pkg.sv */
/*
 * ntbt_pkg: shared constants for the board-test chain block.
 * Assumes nothing of its surroundings; used only by the design top.
 */
package ntbt_pkg;
    // input synchroniser depth for pins
    localparam int unsigned SYNC_STAGES = 3;
    // default chain widths
    localparam int unsigned BC_MISC_W = 128;
    localparam int unsigned MC_MISC_W = 64;
    localparam int unsigned HD_W = 32;
    localparam int unsigned MD_W = 32;
    localparam int unsigned PAR_W = 4;
    // reset values of the outputs
    localparam logic KBSEL_RST = 1'b1;
    localparam logic IRQ_RST = 1'b0;
endpackage : ntbt_pkg

/* File: hw/ntbt_top.sv */
/*
 * ntbt_top: two chained test trees of the two-chip set, board-test pin mux,
 * bidirectional pin direction override while test select is high.
 * Holds the pin synchronisers, the agreement filter, both nand chains,
 * the registered output mux and the registered bidirectional enables.
 * Assumes all chain pins are asynchronous to mclk and the tester paces
 * its test cycles far slower than the synchroniser plus output flop.
 * Assumes the tester keeps to the entry sequences and the lowering order;
 * neither is checked here, a wrong order just gives a wrong toggle count.
 * Assumes the pad ring turns the enable and drive value into the pin.
 */
// How it works
// - bus chip tree drives keyboard select output
// - memory chip tree drives interrupt output
// - test select high turns bidirectionals into inputs
// - bus chain ends power-on reset, test select
// - data, memory data, parity join tree
`timescale 1ns/1ps
`default_nettype none
module ntbt_top #(
    parameter int unsigned BC_W = ntbt_pkg::BC_MISC_W,
    parameter int unsigned MC_W = ntbt_pkg::MC_MISC_W,
    parameter int unsigned HD_W = ntbt_pkg::HD_W,
    parameter int unsigned MD_W = ntbt_pkg::MD_W,
    parameter int unsigned PAR_W = ntbt_pkg::PAR_W
) (
    input wire logic mclk, // system clock
    input wire logic nrst, // async reset, low
    input wire logic test_select_in, // board test select pin
    input wire logic por_in, // power-on reset pin
    input wire logic processor_reset_in, // processor reset pin
    input wire logic [BC_W-1:0] bc_chain_in, // bus chip chain pins, bit 0 first
    input wire logic [MC_W-1:0] mc_chain_in, // memory chip plain chain pins
    input wire logic [HD_W-1:0] host_data_bus_in, // host data pin level
    input wire logic [HD_W-1:0] host_data_bus_fn_out, // core drive value
    input wire logic host_data_bus_fn_oe, // core drive enable
    output logic [HD_W-1:0] host_data_bus_out, // host data pin drive
    output logic host_data_bus_oe, // host data enable
    input wire logic [MD_W-1:0] memory_data_bus_in, // memory data pin level
    input wire logic [MD_W-1:0] memory_data_bus_fn_out, // core drive value
    input wire logic memory_data_bus_fn_oe, // core drive enable
    output logic [MD_W-1:0] memory_data_bus_out, // memory data pin drive
    output logic memory_data_bus_oe, // memory data enable
    input wire logic [PAR_W-1:0] memory_parity_bits_in, // parity pin level
    input wire logic [PAR_W-1:0] memory_parity_bits_fn_out, // core drive value
    input wire logic memory_parity_bits_fn_oe, // core drive enable
    output logic [PAR_W-1:0] memory_parity_bits_out, // parity pin drive
    output logic memory_parity_bits_oe, // parity enable
    input wire logic keyboard_select_fn_n, // functional keyboard select
    input wire logic coproc_interrupt_fn, // functional interrupt
    output logic keyboard_select_out_n, // keyboard select pin
    output logic coproc_interrupt_out // interrupt pin
);
    // chain lengths: pins plus por or processor reset, plus test select
    localparam int unsigned BCN = BC_W + 2;
    localparam int unsigned MCN = MC_W + HD_W + MD_W + PAR_W + 2;
    // one synchronised copy of every chain entry, plus test select on its own last
    localparam int unsigned AW = BCN + MCN + 1;

    // raw pin levels, all asynchronous to mclk
    logic [AW-1:0] pins;
    // three-stage synchroniser
    logic [AW-1:0] s1_r;
    logic [AW-1:0] s2_r;
    logic [AW-1:0] s3_r;
    // accepted pin levels after the agreement filter
    logic [AW-1:0] q_r;
    logic [AW-1:0] q_nxt;
    // chain vectors in tree order, lsb first
    logic [BCN-1:0] bc_v;
    logic [MCN-1:0] mc_v;
    // tree stage outputs; the top bit is the tree output
    logic [BCN-1:0] bc_t;
    logic [MCN-1:0] mc_t;
    // filtered test select and the lagged output mux select
    logic test_q;
    logic mode_r;
    logic mode_nxt;
    // next values of the registered pins
    logic kb_nxt;
    logic irq_nxt;
    logic hd_oe_nxt;
    logic md_oe_nxt;
    logic par_oe_nxt;
    // drive values of the bidirectional pins
    logic [HD_W-1:0] hd_nxt;
    logic [MD_W-1:0] md_nxt;
    logic [PAR_W-1:0] par_nxt;

    // bus chip chain ends with power-on reset, then test select
    assign bc_v = {test_select_in, por_in, bc_chain_in};
    // memory chip chain takes the floated data, memory and parity pins;
    // they only reach the tree as inputs because test mode drops the enables
    assign mc_v = {test_select_in,
                   processor_reset_in,
                   memory_parity_bits_in,
                   memory_data_bus_in,
                   host_data_bus_in,
                   mc_chain_in};
    // test select is carried once more on its own so the mode has one source
    assign pins = {test_select_in, mc_v, bc_v};

    // agreement filter: a level is taken only once stages two and three
    // match, so a pin caught mid-transition cannot flip a tree stage twice
    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < AW; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end else begin
                q_nxt[i] = q_r[i];
            end
        end
    end

    // synchroniser and filter registers; stage one is read only by stage two.
    // all stages clear to 0 like the filter so no false test mode follows reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign test_q = q_r[AW-1];

    // stage i nands its pin with the previous stage; lowering pins from
    // bit 0 upward flips the tail once per step
    // with every pin high the output is 1 for an even stage count, else 0
    generate
        // bus chip tree
        for (genvar g = 0; g < BCN; g++) begin : g_bc
            if (g == 0) begin : g_first
                assign bc_t[g] = ~q_r[g];
            end else begin : g_next
                assign bc_t[g] = ~(q_r[g] & bc_t[g-1]);
            end
        end
        // memory chip tree, taken from the upper part of the filtered pins
        for (genvar g = 0; g < MCN; g++) begin : g_mc
            if (g == 0) begin : g_first
                assign mc_t[g] = ~q_r[BCN+g];
            end else begin : g_next
                assign mc_t[g] = ~(q_r[BCN+g] & mc_t[g-1]);
            end
        end
    endgenerate

    // mode lags test select one cycle so the final toggle, caused by
    // test select itself going low, still reaches the pins
    always_comb begin
        mode_nxt = test_q;

        // tree outputs replace the functional values while mode is on
        if (mode_r) begin
            kb_nxt = bc_t[BCN-1];
            irq_nxt = mc_t[MCN-1];
        end else begin
            kb_nxt = keyboard_select_fn_n;
            irq_nxt = coproc_interrupt_fn;
        end

        // enables drop with the filtered test select, not the lagged mode,
        // so the pins are already inputs before the trees are shown
        hd_oe_nxt = host_data_bus_fn_oe & ~test_q;
        md_oe_nxt = memory_data_bus_fn_oe & ~test_q;
        par_oe_nxt = memory_parity_bits_fn_oe & ~test_q;

        // drive values keep passing; with the enable low they never leave
        hd_nxt = host_data_bus_fn_out;
        md_nxt = memory_data_bus_fn_out;
        par_nxt = memory_parity_bits_fn_out;
    end

    // output registers; the keyboard select idles high out of reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // lagged mode
            mode_r <= 1'b0;
            // tree or functional outputs
            keyboard_select_out_n <= ntbt_pkg::KBSEL_RST;
            coproc_interrupt_out <= ntbt_pkg::IRQ_RST;
            // bidirectional pins start as inputs
            host_data_bus_oe <= 1'b0;
            memory_data_bus_oe <= 1'b0;
            memory_parity_bits_oe <= 1'b0;
            // drive values
            host_data_bus_out <= '0;
            memory_data_bus_out <= '0;
            memory_parity_bits_out <= '0;
        end else begin
            mode_r <= mode_nxt;
            keyboard_select_out_n <= kb_nxt;
            coproc_interrupt_out <= irq_nxt;
            host_data_bus_oe <= hd_oe_nxt;
            memory_data_bus_oe <= md_oe_nxt;
            memory_parity_bits_oe <= par_oe_nxt;
            host_data_bus_out <= hd_nxt;
            memory_data_bus_out <= md_nxt;
            memory_parity_bits_out <= par_nxt;
        end
    end
endmodule : ntbt_top
`default_nettype wire

/* File: verification/ntbt_properties.sv */
/* ntbt_properties: tree output and bus enable checks.
   assumes a bind onto ntbt_top. */
`timescale 1ns/1ps
`default_nettype none
module ntbt_properties #(parameter int unsigned BC_W = 4, parameter int unsigned PAR_W = 1) (
    input wire logic mclk, // clock
    input wire logic nrst, // reset
    input wire logic test_select_in, // mode
    input wire logic por_in, // chain
    input wire logic processor_reset_in, // chain
    input wire logic [BC_W-1:0] bc_chain_in, // chain
    input wire logic [PAR_W-1:0] memory_parity_bits_in, // chain
    input wire logic host_data_bus_oe, // enable
    input wire logic memory_data_bus_oe, // enable
    input wire logic memory_parity_bits_oe, // enable
    input wire logic keyboard_select_out_n, // tree
    input wire logic coproc_interrupt_out // tree
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_on; test_select_in [*8]; endsequence
    // a fall only reaches the output once the previous stage is high
    sequence s_por; s_on ##0 ($fell(por_in) && !bc_chain_in[BC_W-1]); endsequence
    sequence s_prst; s_on ##0 ($fell(processor_reset_in) && !memory_parity_bits_in[PAR_W-1]); endsequence
    property p_hd; s_on |-> !host_data_bus_oe; endproperty
    a_hd: assert property (p_hd) else $error("host bus driven");
    property p_md; s_on |-> !memory_data_bus_oe; endproperty
    a_md: assert property (p_md) else $error("memory bus driven");
    property p_par; s_on |-> !memory_parity_bits_oe; endproperty
    a_par: assert property (p_par) else $error("parity pins driven");
    property p_kb; s_por |-> ##[4:6] $changed(keyboard_select_out_n); endproperty
    a_kb: assert property (p_kb) else $error("bus tree stuck");
    property p_irq; s_prst |-> ##[4:6] $changed(coproc_interrupt_out); endproperty
    a_irq: assert property (p_irq) else $error("memory tree stuck");
    property p_set;
        (test_select_in && $stable(por_in) && $stable(bc_chain_in)) [*8] |->
            $stable(keyboard_select_out_n);
    endproperty
    a_set: assert property (p_set) else $error("bus tree unsettled");
endmodule : ntbt_properties
`default_nettype wire

/* File: verification/ntbt_tester.sv */
/* ntbt_tester: board tester; drives pins at falling mclk.
   assumes the bench resolves bidirectionals against the dut. */
`timescale 1ns/1ps
`default_nettype none
module ntbt_tester (
    input wire logic mclk, // pacing
    output logic [13:0] pin = 14'h0000, // chain pins in order
    output logic ben = 1'b0 // bidir drive
);
    logic [1:0] rs [4] = '{2'h2, 2'h3, 2'h0, 2'h3};
    task automatic cyc();
        repeat (8) @(negedge mclk);
    endtask : cyc
    task automatic enter();
        cyc();
        pin = 14'h2FEF;
        cyc();
        ben = 1'b1;
        cyc();
        foreach (rs[i]) begin
            {pin[4], pin[12]} = rs[i];
            cyc();
        end
    endtask : enter
    task automatic lower(input int i);
        pin[i] = 1'b0;
        cyc();
    endtask : lower
endmodule : ntbt_tester
`default_nettype wire

/* File: verification/ntbt_top_tb.sv */
/* ntbt_top_tb: functional pass-through, then both test trees.
   assumes tester test cycles of 8 mclk. */
`timescale 1ns/1ps
`default_nettype none
module ntbt_top_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic fn = 1'b0;
    logic [13:0] pin;
    logic ben, hd_e, md_e, pa_e, kb_n, irq;
    logic [1:0] hd_o, md_o, hd_l, md_l;
    logic [0:0] pa_o, pa_l;
    int n_mismatch = 0;
    int n_compared = 0;
    always #10 mclk = ~mclk;
    // floating pins show the inverse, never a stale level
    assign hd_l = hd_e ? hd_o : (ben ? pin[8:7] : ~hd_o);
    assign md_l = md_e ? md_o : (ben ? pin[10:9] : ~md_o);
    assign pa_l = pa_e ? pa_o : (ben ? pin[11:11] : ~pa_o);
    ntbt_tester u_tester (.mclk(mclk), .pin(pin), .ben(ben));
    ntbt_top #(.BC_W(4), .MC_W(2), .HD_W(2), .MD_W(2), .PAR_W(1)) u_dut (
        .mclk(mclk), .nrst(nrst), .test_select_in(pin[13]), .por_in(pin[4]),
        .processor_reset_in(pin[12]), .bc_chain_in(pin[3:0]), .mc_chain_in(pin[6:5]),
        .host_data_bus_in(hd_l), .host_data_bus_fn_out({fn, ~fn}), .host_data_bus_fn_oe(fn),
        .host_data_bus_out(hd_o), .host_data_bus_oe(hd_e), .memory_data_bus_in(md_l),
        .memory_data_bus_fn_out({fn, ~fn}), .memory_data_bus_fn_oe(fn),
        .memory_data_bus_out(md_o), .memory_data_bus_oe(md_e), .memory_parity_bits_in(pa_l),
        .memory_parity_bits_fn_out(fn), .memory_parity_bits_fn_oe(fn),
        .memory_parity_bits_out(pa_o), .memory_parity_bits_oe(pa_e),
        .keyboard_select_fn_n(fn), .coproc_interrupt_fn(~fn),
        .keyboard_select_out_n(kb_n), .coproc_interrupt_out(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic t_func();
        fn = 1'b1;
        repeat (8) @(negedge mclk);
        chk({kb_n, irq, hd_e, md_e, pa_e, hd_o[1], md_o[0], pa_o}, 8'hBD);
        fn = 1'b0;
        repeat (8) @(negedge mclk);
        chk({kb_n, irq, hd_e, md_e, pa_e, hd_o[1], md_o[0], pa_o}, 8'h42);
        fn = 1'b1;
        repeat (8) @(negedge mclk);
        $display("t_func done");
    endtask : t_func
    task automatic t_chain();
        u_tester.enter();
        chk({3'h0, kb_n, irq, hd_e, md_e, pa_e}, 8'h10);
        // bus tree has an even stage count, memory tree an odd one
        for (int k = 0; k < 13; k++) begin
            u_tester.lower(k);
            chk({6'h00, kb_n, irq}, k[0] ? (k < 5 ? 8'h02 : 8'h01) : 8'h00);
        end
        $display("t_chain done");
    endtask : t_chain
    initial begin
        repeat (1000) @(posedge mclk);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        t_func();
        t_chain();
        close_out();
    end
endmodule : ntbt_top_tb
bind ntbt_top ntbt_properties #(.BC_W(BC_W), .PAR_W(PAR_W)) u_props (.mclk(mclk), .nrst(nrst),
    .test_select_in(test_select_in), .por_in(por_in), .processor_reset_in(processor_reset_in),
    .bc_chain_in(bc_chain_in), .memory_parity_bits_in(memory_parity_bits_in),
    .host_data_bus_oe(host_data_bus_oe), .memory_data_bus_oe(memory_data_bus_oe),
    .memory_parity_bits_oe(memory_parity_bits_oe),
    .keyboard_select_out_n(keyboard_select_out_n), .coproc_interrupt_out(coproc_interrupt_out));
`default_nettype wire
